// ==== logic/iocg_top.v ====
`timescale 1ns/1ps
`include "iocg_regs.vh"
// I/O cell: output register path with single and double rate, input gearbox.
// The output clock and the edge clock are modelled as a phase that toggles
// every reference cycle; phase high is the clock-high half period.
module iocg_top #(
	parameter RIGHT_EDGE = `IOCG_RIGHT_EDGE,
	parameter GEAR_W     = `IOCG_GEAR_W,
	parameter FIFO_DEPTH = `IOCG_FIFO_DEPTH
) (
	input  wire                   ref_clk_in,
	input  wire                   rst_b_in,
	input  wire [`IOCG_MODE_W-1:0] out_mode_in,
	input  wire                   sdr_latch_in,
	input  wire                   first_data_in,
	input  wire                   second_data_in,
	input  wire                   quadrature_write_strobe_in,
	input  wire                   out_enable_in,
	input  wire                   hs_data_in,
	input  wire                   align_update_in,
	input  wire                   align_phase_select_in,
	input  wire                   core_ready_in,
	output wire                   out_phase_out,
	output wire                   pad_out,
	output wire                   pad_n_out,
	output wire                   pad_oe_out,
	output wire [GEAR_W-1:0]      core_data_out,
	output wire                   core_valid_out,
	output wire                   slow_tick_out,
	output wire                   gbx_overrun_out
);
	reg                phase_ff;
	reg                rise_phase_reg;
	reg                hold_ff;
	reg                fall_phase_reg;
	reg                pad_ff;
	reg                pad_n_ff;
	reg                pad_oe_ff;
	reg                nxt_pad;
	reg [`IOCG_MODE_W-1:0] mode_eff;
	reg                s1_rise_ff;
	reg                s1_fall_ff;
	reg [`IOCG_SHIFT_W-1:0] shift_ff;
	reg                sel_ff;
	reg [GEAR_W-1:0]   s2_ff;
	reg [GEAR_W-1:0]   s3_ff;
	reg                s3_valid_ff;
	reg [`IOCG_SLOW_W-1:0] slow_cnt_ff;
	reg                slow_tick_ff;
	reg                overrun_ff;
	reg [GEAR_W-1:0]   core_data_ff;
	reg                core_valid_ff;
	wire               rise_edge;
	wire               fall_edge;
	wire               selector;
	wire               fifo_wr_ready;
	wire               fifo_rd_valid;
	wire [GEAR_W-1:0]  fifo_rd_data;
	wire               fifo_pop;
	wire               slow_tick;

	// Rising edge of the modelled clock is the cycle where the phase goes high.
	assign rise_edge = ~phase_ff;
	assign fall_edge = phase_ff;
	assign slow_tick = (slow_cnt_ff == `IOCG_SLOW_LAST);

	// Memory mode exists only on right-edge cells; elsewhere it falls back to generic.
	always @* begin
		mode_eff = out_mode_in;
		if (out_mode_in == `IOCG_MODE_DDR_MEM && RIGHT_EDGE == 0) begin
			mode_eff = `IOCG_MODE_DDR_GEN;
		end else if (out_mode_in == `IOCG_MODE_DDR_MEM) begin
			mode_eff = `IOCG_MODE_DDR_MEM; // R07
		end
	end

	// Selector for the phase multiplexer: clock in generic mode, strobe in memory mode.
	assign selector = (mode_eff == `IOCG_MODE_DDR_MEM) ? quadrature_write_strobe_in // R08
	                  : ~phase_ff; // R06

	always @* begin
		nxt_pad = pad_ff;
		if (mode_eff == `IOCG_MODE_SDR) begin
			if (sdr_latch_in) begin
				if (fall_edge) begin
					nxt_pad = first_data_in; // R03
				end
			end else if (rise_edge) begin
				nxt_pad = first_data_in; // R02
			end
		end else if (selector) begin
			nxt_pad = rise_phase_reg; // R14
		end else begin
			nxt_pad = fall_phase_reg; // R14
		end
	end

	always @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			phase_ff       <= 1'b0;
			rise_phase_reg <= 1'b0;
			hold_ff        <= 1'b0;
			fall_phase_reg <= 1'b0;
			pad_ff         <= 1'b0;
			pad_n_ff       <= 1'b1;
			pad_oe_ff      <= 1'b0;
		end else begin
			phase_ff  <= ~phase_ff;
			pad_oe_ff <= out_enable_in;
			if (rise_edge) begin
				rise_phase_reg <= first_data_in; // R04
				hold_ff        <= second_data_in; // R04
			end
			if (fall_edge) begin
				fall_phase_reg <= hold_ff; // R05
			end
			pad_ff   <= nxt_pad; // R01
			pad_n_ff <= ~nxt_pad; // R09
		end
	end

	assign out_phase_out = phase_ff;
	assign pad_out       = pad_ff;
	assign pad_n_out     = pad_n_ff;
	assign pad_oe_out    = pad_oe_ff;

	// Input gearbox, stage one: one sample per edge-clock half period.
	always @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s1_rise_ff <= 1'b0;
			s1_fall_ff <= 1'b0;
			shift_ff   <= {`IOCG_SHIFT_W{1'b0}};
		end else begin
			if (rise_edge) begin
				s1_rise_ff <= hs_data_in; // R11
			end
			if (fall_edge) begin
				s1_fall_ff <= hs_data_in; // R11
			end
			if (rise_edge) begin
				shift_ff <= {shift_ff[`IOCG_SHIFT_W-3:0], s1_rise_ff, s1_fall_ff}; // R10
			end
		end
	end

	// Stage two: phase select takes effect at an alignment load; word built on slow tick.
	always @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sel_ff       <= 1'b0;
			s2_ff        <= {GEAR_W{1'b0}};
			slow_cnt_ff  <= {`IOCG_SLOW_W{1'b0}};
			slow_tick_ff <= 1'b0;
		end else begin
			slow_cnt_ff  <= slow_cnt_ff + 1'b1;
			slow_tick_ff <= slow_tick;
			if (align_update_in) begin
				sel_ff <= align_phase_select_in; // R12
			end
			if (slow_tick) begin
				s2_ff <= sel_ff ? shift_ff[GEAR_W:1] : shift_ff[GEAR_W-1:0]; // R12
			end
		end
	end

	// Stage three: slow-clock register; it holds its pending word while the FIFO is full.
	always @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s3_ff       <= {GEAR_W{1'b0}};
			s3_valid_ff <= 1'b0;
			overrun_ff  <= 1'b0;
		end else begin
			if (slow_tick) begin
				if (s3_valid_ff && !fifo_wr_ready) begin
					overrun_ff <= 1'b1;
				end else begin
					s3_ff       <= s2_ff; // R13
					s3_valid_ff <= 1'b1; // R13
				end
			end else if (s3_valid_ff && fifo_wr_ready) begin
				s3_valid_ff <= 1'b0;
			end
		end
	end

	iocg_fifo #(
		.WIDTH (GEAR_W),
		.DEPTH (FIFO_DEPTH),
		.AW    (2)
	) u_fifo (
		.ref_clk_in   (ref_clk_in),
		.rst_b_in     (rst_b_in),
		.wr_valid_in  (s3_valid_ff),
		.wr_ready_out (fifo_wr_ready),
		.wr_data_in   (s3_ff),
		.rd_valid_out (fifo_rd_valid),
		.rd_ready_in  (fifo_pop),
		.rd_data_out  (fifo_rd_data)
	);

	// Output skid register so the core sees flip-flop outputs.
	assign fifo_pop = ~core_valid_ff | core_ready_in;

	always @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			core_data_ff  <= {GEAR_W{1'b0}};
			core_valid_ff <= 1'b0;
		end else if (fifo_pop) begin
			core_data_ff  <= fifo_rd_data;
			core_valid_ff <= fifo_rd_valid;
		end
	end

	assign core_data_out   = core_data_ff;
	assign core_valid_out  = core_valid_ff;
	assign slow_tick_out   = slow_tick_ff;
	assign gbx_overrun_out = overrun_ff;
endmodule

// ==== logic/iocg_regs.vh ====
// Summary of operation
// R01 - Core output data is registered before it reaches the pad buffer.
// R02 - Single-rate mode sends the first data input through one storage element.
// R03 - That single-rate element works as an edge register or a transparent latch.
// R04 - Generic double-rate mode registers both data inputs on the rising edge.
// R05 - Held second data moves to the falling-phase register on the falling edge.
// R06 - Generic double-rate output alternates between phase registers using the clock.
// R07 - Right-edge cells add a memory double-rate mode to the common modes.
// R08 - Memory double-rate mode selects phase registers with the quadrature write strobe.
// R09 - A neighbouring cell drives the complementary, inverted pad output; here the same cell drives pad_n_out from its own pad_n_ff.
// R10 - The input gearbox is a three-stage register pipeline.
// R11 - Stage one samples high-speed data on both edge-clock edges.
// R12 - Stage two aligns data by the alignment-load and phase-select controls.
// R13 - Stage three hands aligned data to the core on the slow clock.
// R14 - Double-rate output shows rise value while selector high, fall value while low.
`ifndef IOCG_REGS_VH
`define IOCG_REGS_VH
`define IOCG_MODE_W        2
`define IOCG_MODE_SDR      2'h0
`define IOCG_MODE_DDR_GEN  2'h1
`define IOCG_MODE_DDR_MEM  2'h2
`define IOCG_GEAR_W        4
`define IOCG_SHIFT_W       6
`define IOCG_SLOW_W        2
`define IOCG_SLOW_LAST     2'h3
`define IOCG_FIFO_DEPTH    4
`define IOCG_RIGHT_EDGE    1
`endif

// ==== logic/iocg_fifo.v ====
`timescale 1ns/1ps
// Small synchronous FIFO with valid and ready on both sides.
module iocg_fifo #(
	parameter WIDTH = 4,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             ref_clk_in,
	input  wire             rst_b_in,
	input  wire             wr_valid_in,
	output wire             wr_ready_out,
	input  wire [WIDTH-1:0] wr_data_in,
	output wire             rd_valid_out,
	input  wire             rd_ready_in,
	output wire [WIDTH-1:0] rd_data_out
);
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_ff;
	reg [AW-1:0]    rd_ptr_ff;
	reg [AW:0]      count_ff;
	wire            push;
	wire            pop;
	integer         i;

	assign wr_ready_out = (count_ff != DEPTH[AW:0]);
	assign rd_valid_out = (count_ff != {(AW+1){1'b0}});
	assign rd_data_out  = mem_ff[rd_ptr_ff];
	assign push         = wr_valid_in & wr_ready_out;
	assign pop          = rd_valid_out & rd_ready_in;

	always @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff  <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_ff[i] <= {WIDTH{1'b0}};
			end
		end else begin
			if (push) begin
				mem_ff[wr_ptr_ff] <= wr_data_in;
				wr_ptr_ff         <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
				                     : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
				             : rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end
endmodule

// ==== dv/iocg_checker.sv ====
`timescale 1ns/1ps
`include "iocg_regs.vh"
module iocg_checker #(
	parameter GEAR_W = 4
) (
	input wire                    ref_clk_in,
	input wire                    rst_b_in,
	input wire [`IOCG_MODE_W-1:0] out_mode_in,
	input wire                    sdr_latch_in,
	input wire                    first_data_in,
	input wire                    second_data_in,
	input wire                    quadrature_write_strobe_in,
	input wire                    out_enable_in,
	input wire                    core_ready_in,
	input wire                    out_phase_out,
	input wire                    pad_out,
	input wire                    pad_n_out,
	input wire                    pad_oe_out,
	input wire [GEAR_W-1:0]       core_data_out,
	input wire                    core_valid_out,
	input wire                    slow_tick_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	wire sdr = out_mode_in == `IOCG_MODE_SDR;
	wire gen = out_mode_in == `IOCG_MODE_DDR_GEN;
	wire mem = out_mode_in == `IOCG_MODE_DDR_MEM;
	a_pad_pair: assert property (pad_n_out == !pad_out)
		else $error("pad pair not inverse");
	a_phase_toggle: assert property (rst_b_in |=> out_phase_out != $past(out_phase_out))
		else $error("phase did not toggle");
	a_oe_follow: assert property (rst_b_in |=> pad_oe_out == $past(out_enable_in))
		else $error("drive enable late");
	a_sdr_hold: assert property (sdr && !sdr_latch_in && out_phase_out |=> $stable(pad_out))
		else $error("register mode moved off rise");
	a_latch_pass: assert property (
		sdr && sdr_latch_in && out_phase_out |=> pad_out == $past(first_data_in))
		else $error("latch not transparent");
	a_sdr_load: assert property (
		sdr && !sdr_latch_in && !out_phase_out |=> pad_out == $past(first_data_in))
		else $error("register mode missed rise data");
	a_ddr_gen: assert property (
		!out_phase_out && gen ##1 gen ##1 gen ##1 gen |->
		pad_out == $past(first_data_in, 3) ##1 pad_out == $past(second_data_in, 4))
		else $error("generic double rate order");
	a_mem_rise: assert property (
		(mem && $stable(first_data_in))[*4] ##1 mem && quadrature_write_strobe_in
		|=> pad_out == $past(first_data_in, 2))
		else $error("strobe did not pick rise value");
	a_tick_period: assert property (slow_tick_out |=> (!slow_tick_out)[*3] ##1 slow_tick_out)
		else $error("slow tick period");
	a_core_hold: assert property (
		core_valid_out && !core_ready_in |=> core_valid_out && $stable(core_data_out))
		else $error("core word dropped while stalled");
endmodule
bind iocg_top iocg_checker #(.GEAR_W(GEAR_W)) u_chk (.*);

// ==== dv/iocg_ext_dev.sv ====
`timescale 1ns/1ps
module iocg_ext_dev (
	input  wire  ref_clk_in,
	input  wire  pad_in,
	input  wire  pad_n_in,
	input  wire  pad_oe_in,
	input  wire  bit_in,
	output logic hs_data_out,
	output logic bad_pair_out
);
	initial bad_pair_out = 1'b0;
	always @(negedge ref_clk_in) begin
		hs_data_out <= bit_in;
	end
	always @(posedge ref_clk_in) begin
		if (pad_oe_in && pad_in === pad_n_in) begin
			bad_pair_out <= 1'b1;
		end
	end
endmodule

// ==== dv/iocg_tb.sv ====
`timescale 1ns/1ps
`include "iocg_regs.vh"
module tb;
	logic       ref_clk_in = 0;
	logic       rst_b_in = 0;
	logic [1:0] mode = 0;
	logic       lat = 0, fst = 0, snd = 0, stb = 0, oe = 0, upd = 0, psel = 0, rdy = 1, lvl = 0;
	wire        phase, pad, pad_n, pad_oe, cval, tick, ovr, hs, bad;
	wire  [3:0] cdata;
	int         n_mismatch = 0;
	int         n_checks = 0;
	always #12.5 ref_clk_in = ~ref_clk_in;
	iocg_top u_dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .out_mode_in(mode),
		.sdr_latch_in(lat), .first_data_in(fst), .second_data_in(snd),
		.quadrature_write_strobe_in(stb), .out_enable_in(oe), .hs_data_in(hs),
		.align_update_in(upd), .align_phase_select_in(psel), .core_ready_in(rdy),
		.out_phase_out(phase), .pad_out(pad), .pad_n_out(pad_n), .pad_oe_out(pad_oe),
		.core_data_out(cdata), .core_valid_out(cval), .slow_tick_out(tick),
		.gbx_overrun_out(ovr));
	iocg_ext_dev u_ext (.ref_clk_in(ref_clk_in), .pad_in(pad), .pad_n_in(pad_n),
		.pad_oe_in(pad_oe), .bit_in(lvl), .hs_data_out(hs), .bad_pair_out(bad));
	task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t_sdr;
		mode = `IOCG_MODE_SDR;
		fst = 1;
		oe = 1;
		cyc(4);
		chk("pad", 4'h1, pad);
		chk("pad_n", 4'h0, pad_n);
		chk("oe", 4'h1, pad_oe);
		lat = 1;
		cyc(1);
		// The data falls during a clock-high half, where a register would hold.
		fst = 0;
		cyc(1);
		chk("latch", 4'h0, pad);
		cyc(1);
		lat = 0;
	endtask
	task automatic t_ddr;
		logic a;
		mode = `IOCG_MODE_DDR_GEN;
		fst = 1;
		snd = 0;
		cyc(6);
		a = pad;
		chk("phase", 4'h1, phase);
		chk("ddr rise", 4'h1, a);
		cyc(1);
		chk("ddr swap", 4'h1, a ^ pad);
		chk("ddr fall", 4'h0, pad);
	endtask
	task automatic t_mem;
		mode = `IOCG_MODE_DDR_MEM;
		stb = 1;
		cyc(6);
		chk("mem rise", 4'h1, pad);
		stb = 0;
		cyc(3);
		chk("mem fall", 4'h0, pad);
	endtask
	// Rise samples see zero and fall samples see one, so the two alignments differ.
	task automatic alt_bits(input int n);
		repeat (n) begin
			lvl <= ~phase;
			cyc(1);
		end
	endtask
	task automatic t_gear;
		upd = 1;
		psel = 0;
		alt_bits(40);
		chk("word", 4'h5, cdata);
		chk("overrun", 4'h0, ovr);
		psel = 1;
		alt_bits(40);
		chk("aligned word", 4'hA, cdata);
		rdy = 0;
		upd = 0;
		cyc(60);
		chk("valid", 4'h1, cval);
		chk("held word", 4'hA, cdata);
		chk("overrun", 4'h1, ovr);
	endtask
	initial begin
		cyc(16);
		chk("reset pad_n", 4'h1, pad_n);
		rst_b_in = 1;
		cyc(2);
		t_sdr;
		t_ddr;
		t_mem;
		t_gear;
		chk("pair", 4'h0, bad);
		complete_run;
	end
	initial begin
		#100000;
		n_mismatch++;
		complete_run;
	end
endmodule
